// file: core/dtp_pattern_gen.sv
// Purpose: Test pattern insertion on four output datapaths, calibration error status
// Assumes: All inputs synchronous to core_clk, register port driven by the serial config logic
// Notes: Read data appears one cycle after the read strobe

`timescale 1ns/100ps

// Operation
// R1 - Eight read-only calibration error flags, one per channel, mark an invalid black calibration result.
// R2 - Control bit 0 replaces output data with synthesized patterns and is clear after reset.
// R3 - Control bit 1 makes the inserted pattern increment per word, otherwise it stays constant.
// R4 - Control bit 2 inserts a pseudo-random sequence instead of pixel data and is clear after reset.
// R5 - Control bit 3 keeps frame and line structure around the patterns, otherwise they run unframed.
// R6 - Datapath 0 takes its low pattern byte from bits 7:0 of address 146, reset 0x00.
// R7 - Datapath 1 takes its low pattern byte from bits 15:8 of address 146, reset 0x01.
// R8 - Datapath 2 takes its low pattern byte from bits 7:0 of address 147, reset 0x02.
// R9 - Datapath 3 takes its low pattern byte from bits 15:8 of address 147, reset 0x03.
// R10 - The two high pattern bits per datapath come from address 150, two bits per path, reset zero.
// R11 - Pseudo-random insertion wins over pattern insertion, and each datapath has its own pattern.
module dtp_pattern_gen (
	input wire logic core_clk,
	input wire logic rst,
	input wire dtp_pkg::dtp_reg_req_t reg_req,
	output dtp_pkg::dtp_reg_rsp_t reg_rsp,
	input wire dtp_pkg::dtp_stream_t pix_in,
	input wire logic cal_done,
	input wire logic [7:0] cal_short,
	output dtp_pkg::dtp_stream_t data_out
);
	import dtp_pkg::*;

	dtp_state_t state;
	dtp_state_t next_state;
	dtp_lanes_t base_pattern;
	dtp_lanes_t next_count;
	dtp_lanes_t next_prbs;
	dtp_lanes_t lane_word;
	logic insert_on;
	logic prbs_on;
	logic inc_on;
	logic framed;
	logic word_step;

	assign insert_on = state.ctrl[DTP_BIT_INSERT]; // R2
	assign prbs_on = state.ctrl[DTP_BIT_PRBS]; // R4
	assign inc_on = state.ctrl[DTP_BIT_INC];
	assign framed = state.ctrl[DTP_BIT_FRAMED];
	// Unframed patterns flow every cycle, framed ones only on pixel slots
	assign word_step = (insert_on | prbs_on) & (framed ? pix_in.valid : 1'b1); // R5

	// ----------------------------------------
	// Per-lane pattern sources
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < DTP_LANES; g++) begin : g_lane
			logic [7:0] low_byte;
			if (g < 2) begin : g_lo
				assign low_byte = state.low_01[8*g +: 8]; // R6 R7
			end else begin : g_hi
				assign low_byte = state.low_23[8*(g-2) +: 8]; // R8 R9
			end
			assign base_pattern[g] = {state.high[2*g +: 2], low_byte}; // R10
			// Counter restarts from the programmed value whenever both pattern and pseudo-random insertion are off
			always_comb begin
				if (!(insert_on | prbs_on)) begin
					next_count[g] = base_pattern[g];
				end else if (word_step && inc_on) begin
					next_count[g] = state.count[g] + 10'h001; // R3
				end else begin
					next_count[g] = state.count[g];
				end
			end
			// x^10 + x^7 + 1 maximal length sequence, seeds differ per lane
			always_comb begin
				if (!prbs_on) begin
					next_prbs[g] = DTP_PRBS_SEED + 10'(g);
				end else if (word_step) begin
					next_prbs[g] = {state.prbs[g][8:0], state.prbs[g][9] ^ state.prbs[g][6]};
				end else begin
					next_prbs[g] = state.prbs[g];
				end
			end
			always_comb begin
				if (prbs_on) begin
					lane_word[g] = state.prbs[g]; // R11 R4
				end else if (inc_on) begin
					lane_word[g] = state.count[g]; // R3
				end else begin
					lane_word[g] = base_pattern[g];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_state.count = next_count;
		next_state.prbs = next_prbs;

		if (reg_req.wr) begin
			case (reg_req.addr)
				DTP_ADDR_CTRL: begin
					next_state.ctrl = reg_req.wdata[DTP_CTRL_W-1:0];
				end
				DTP_ADDR_LOW_01: begin
					next_state.low_01 = reg_req.wdata;
				end
				DTP_ADDR_LOW_23: begin
					next_state.low_23 = reg_req.wdata;
				end
				DTP_ADDR_HIGH: begin
					next_state.high = reg_req.wdata[7:0];
				end
				default: begin
					next_state.ctrl = state.ctrl;
				end
			endcase
		end

		// Flags follow the latest calibration result, so a good run clears them
		if (cal_done) begin
			next_state.cal_err = cal_short; // R1
		end

		next_state.rsp.rvalid = reg_req.rd;
		if (reg_req.rd) begin
			case (reg_req.addr)
				DTP_ADDR_CAL_ERR: begin
					next_state.rsp.rdata = {8'h00, state.cal_err}; // R1
				end
				DTP_ADDR_CTRL: begin
					next_state.rsp.rdata = {12'h000, state.ctrl};
				end
				DTP_ADDR_LOW_01: begin
					next_state.rsp.rdata = state.low_01;
				end
				DTP_ADDR_LOW_23: begin
					next_state.rsp.rdata = state.low_23;
				end
				DTP_ADDR_HIGH: begin
					next_state.rsp.rdata = {8'h00, state.high};
				end
				DTP_ADDR_RSV_CFG_B: begin
					next_state.rsp.rdata = DTP_RSV_CFG_B;
				end
				DTP_ADDR_RSV_CFG_D: begin
					next_state.rsp.rdata = DTP_RSV_CFG_D;
				end
				default: begin
					next_state.rsp.rdata = DTP_RSV_ZERO;
				end
			endcase
		end

		if (!(insert_on | prbs_on)) begin
			next_state.out = pix_in;
		end else if (framed) begin
			next_state.out.valid = pix_in.valid; // R5
			next_state.out.frame_valid = pix_in.frame_valid;
			next_state.out.line_valid = pix_in.line_valid;
			next_state.out.data = pix_in.valid ? lane_word : pix_in.data;
		end else begin
			next_state.out.valid = 1'b1; // R5
			next_state.out.frame_valid = 1'b0;
			next_state.out.line_valid = 1'b0;
			next_state.out.data = lane_word;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= '0;
			state.ctrl <= DTP_RST_CTRL; // R2 R4
			state.low_01 <= DTP_RST_LOW_01; // R6 R7
			state.low_23 <= DTP_RST_LOW_23; // R8 R9
			state.high <= DTP_RST_HIGH; // R10
			state.cal_err <= DTP_RST_CAL_ERR;
		end else begin
			state <= next_state;
		end
	end

	assign reg_rsp = state.rsp;
	assign data_out = state.out;

endmodule : dtp_pattern_gen

// file: core/dtp_pkg.sv
// Purpose: Shared constants and types of the datapath test pattern generator
// Assumes: 10-bit words on four output datapaths, 16-bit configuration registers
// Notes: Register addresses are the device's configuration addresses

package dtp_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int DTP_LANES = 4;
	localparam int DTP_WORD_W = 10;
	localparam int DTP_ADDR_W = 9;
	localparam int DTP_REG_W = 16;
	localparam int DTP_CAL_CH = 8;

	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [8:0] DTP_ADDR_CAL_ERR = 9'h088;
	localparam logic [8:0] DTP_ADDR_RSV_STAT_A = 9'h089;
	localparam logic [8:0] DTP_ADDR_RSV_STAT_B = 9'h08A;
	localparam logic [8:0] DTP_ADDR_RSV_STAT_C = 9'h08B;
	localparam logic [8:0] DTP_ADDR_RSV_CFG_A = 9'h08C;
	localparam logic [8:0] DTP_ADDR_RSV_CFG_B = 9'h08D;
	localparam logic [8:0] DTP_ADDR_CTRL = 9'h090;
	localparam logic [8:0] DTP_ADDR_RSV_CFG_C = 9'h091;
	localparam logic [8:0] DTP_ADDR_LOW_01 = 9'h092;
	localparam logic [8:0] DTP_ADDR_LOW_23 = 9'h093;
	localparam logic [8:0] DTP_ADDR_RSV_CFG_D = 9'h094;
	localparam logic [8:0] DTP_ADDR_HIGH = 9'h096;

	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	localparam int DTP_BIT_INSERT = 0;
	localparam int DTP_BIT_INC = 1;
	localparam int DTP_BIT_PRBS = 2;
	localparam int DTP_BIT_FRAMED = 3;
	localparam int DTP_CTRL_W = 4;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [3:0] DTP_RST_CTRL = 4'h0;
	localparam logic [15:0] DTP_RST_LOW_01 = 16'h0100;
	localparam logic [15:0] DTP_RST_LOW_23 = 16'h0302;
	localparam logic [7:0] DTP_RST_HIGH = 8'h00;
	localparam logic [7:0] DTP_RST_CAL_ERR = 8'h00;
	localparam logic [15:0] DTP_RSV_ZERO = 16'h0000;
	localparam logic [15:0] DTP_RSV_CFG_B = 16'hFFFF;
	localparam logic [15:0] DTP_RSV_CFG_D = 16'h0504;

	// Per-lane PRBS seeds are this value plus the lane number, each lane seed must be nonzero to keep its sequence alive
	localparam logic [9:0] DTP_PRBS_SEED = 10'h001;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef logic [DTP_WORD_W-1:0] dtp_word_t;
	typedef dtp_word_t [DTP_LANES-1:0] dtp_lanes_t;

	typedef struct packed {
		logic [DTP_ADDR_W-1:0] addr;
		logic wr;
		logic rd;
		logic [DTP_REG_W-1:0] wdata;
	} dtp_reg_req_t;

	typedef struct packed {
		logic [DTP_REG_W-1:0] rdata;
		logic rvalid;
	} dtp_reg_rsp_t;

	typedef struct packed {
		dtp_lanes_t data;
		logic valid;
		logic frame_valid;
		logic line_valid;
	} dtp_stream_t;

	typedef struct packed {
		logic [DTP_CTRL_W-1:0] ctrl;
		logic [DTP_REG_W-1:0] low_01;
		logic [DTP_REG_W-1:0] low_23;
		logic [7:0] high;
		logic [DTP_CAL_CH-1:0] cal_err;
		dtp_lanes_t count;
		dtp_lanes_t prbs;
		dtp_stream_t out;
		dtp_reg_rsp_t rsp;
	} dtp_state_t;

endpackage : dtp_pkg

// file: verification/dtp_checker_assertions.sv
// Purpose: Port checks of the datapath test pattern generator
// Assumes: Control bits shadowed from register writes
// Notes: Shadow tells the stream checks which mode is live
`timescale 1ns/100ps
module dtp_checker (
	input wire logic core_clk,
	input wire logic rst,
	input wire dtp_pkg::dtp_reg_req_t reg_req,
	input wire dtp_pkg::dtp_reg_rsp_t reg_rsp,
	input wire dtp_pkg::dtp_stream_t pix_in,
	input wire logic cal_done,
	input wire logic [7:0] cal_short,
	input wire dtp_pkg::dtp_stream_t data_out
);
	import dtp_pkg::*;
	logic [3:0] c;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			c <= 4'h0;
		else if (reg_req.wr && reg_req.addr == 9'h090)
			c <= reg_req.wdata[3:0];
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_cal_flags: assert property (cal_done ##1 (reg_req.rd && reg_req.addr == 9'h088 && !cal_done)
		|=> reg_rsp.rdata == {8'h00, $past(cal_short, 2)}) else $error("flag read wrong");
	a_read_answer: assert property (reg_req.rd |=> reg_rsp.rvalid) else $error("read not answered");
	a_pass_thru: assert property (!(c[0] | c[2]) |=> data_out == $past(pix_in)) else $error("no pass");
	a_unframed_flags: assert property ((c[0] | c[2]) && !c[3]
		|=> data_out.valid && !data_out.frame_valid && !data_out.line_valid) else $error("unframed flags");
	a_framed_copy: assert property ((c[0] | c[2]) && c[3] |=> {data_out.valid, data_out.frame_valid,
		data_out.line_valid} == $past({pix_in.valid, pix_in.frame_valid, pix_in.line_valid})) else $error("framing");
	a_const_hold: assert property ((c == 4'h1 && !reg_req.wr) ##1 c == 4'h1
		|=> $stable(data_out.data)) else $error("constant moved");
	a_inc_step: assert property ((c == 4'h3) [*2] |=> data_out.data[0] == $past(data_out.data[0]) + 10'h001
		&& data_out.data[3] == $past(data_out.data[3]) + 10'h001) else $error("no increment");
	a_prbs_step: assert property ((c[2] && !c[3]) [*2] |=> data_out.data[1] == {$past(data_out.data[1][8:0]),
		$past(data_out.data[1][9] ^ data_out.data[1][6])}) else $error("prbs step");
endmodule : dtp_checker

// file: verification/dtp_rx_model.sv
// Purpose: Receiver model capturing the output stream
// Assumes: A word is taken on every edge that marks it valid
// Notes: Keeps the last captured lanes for the bench
`timescale 1ns/100ps
module dtp_rx_model (
	input wire logic core_clk,
	input wire dtp_pkg::dtp_stream_t data_out,
	output dtp_pkg::dtp_lanes_t last
);
	import dtp_pkg::*;
	always @(posedge core_clk) begin
		if (data_out.valid)
			last <= data_out.data;
	end
endmodule : dtp_rx_model

// file: verification/datapath_test_pattern_gen_tb.sv
// Purpose: Self-checking bench of the datapath test pattern generator
// Assumes: Inputs change at the falling edge
// Notes: Register reads are scored from a queue by a watcher
`timescale 1ns/100ps
module datapath_test_pattern_gen_tb;
	import dtp_pkg::*;
	logic core_clk, rst, cal_done;
	logic [7:0] cal_short, hi;
	logic [15:0] rnd;
	logic [31:0] lo;
	dtp_reg_req_t req;
	dtp_reg_rsp_t rsp;
	dtp_stream_t pix, dout, prev;
	dtp_lanes_t last, b, e;
	logic [15:0] exp_q [$];
	int n_mismatch = 0, samples_checked = 0, cyc = 0;
	logic [8:0] ra [9] = '{9'h088, 9'h090, 9'h092, 9'h093, 9'h096, 9'h08D, 9'h094, 9'h091, 9'h08C};
	logic [15:0] re [9] = '{16'h0, 16'h0, 16'h0100, 16'h0302, 16'h0, 16'hFFFF, 16'h0504, 16'h0, 16'h0};
	dtp_pattern_gen dut (.core_clk(core_clk), .rst(rst), .reg_req(req), .reg_rsp(rsp), .pix_in(pix),
		.cal_done(cal_done), .cal_short(cal_short), .data_out(dout));
	dtp_rx_model u_rx (.core_clk(core_clk), .data_out(dout), .last(last));
	task chk(input logic [42:0] s, input logic [42:0] x);
		samples_checked++;
		if (s !== x) begin
			n_mismatch++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, x);
		end
	endtask : chk
	task conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	// Bus tasks wait a falling edge first so a strobe never drops and rises in one step
	task wr(input logic [8:0] a, input logic [15:0] d);
		@(negedge core_clk);
		req.addr = a;
		req.wdata = d;
		req.wr = 1'b1;
		@(negedge core_clk);
		req.wr = 1'b0;
	endtask : wr
	task rd(input logic [8:0] a, input logic [15:0] x);
		@(negedge core_clk);
		exp_q.push_back(x);
		req.addr = a;
		req.rd = 1'b1;
		@(negedge core_clk);
		req.rd = 1'b0;
	endtask : rd
	task drive();
		rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
		pix = {rnd[9:0], rnd[15:6], rnd[11:2], ~rnd[9:0], rnd[2:0]};
		prev = pix;
	endtask : drive
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(negedge core_clk) begin
		if (rsp.rvalid === 1'b1)
			chk(43'(rsp.rdata), 43'(exp_q.pop_front()));
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_mismatch++;
			conclude();
		end
	end
	initial begin
		req = '0;
		pix = '0;
		cal_done = 1'b0;
		cal_short = 8'h00;
		rnd = 16'h7401;
		rst = 1'b1;
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		for (int i = 0; i < 9; i++)
			rd(ra[i], re[i]);
		drive();
		cal_short = rnd[7:0];
		cal_done = 1'b1;
		@(negedge core_clk);
		cal_done = 1'b0;
		rd(9'h088, {8'h00, cal_short});
		for (int k = 0; k < 4; k++) begin
			drive();
			@(negedge core_clk);
			chk(dout, prev);
		end
		drive();
		lo = {rnd, ~rnd};
		hi = rnd[15:8];
		wr(9'h092, lo[15:0]);
		wr(9'h093, lo[31:16]);
		wr(9'h096, {8'h00, hi});
		for (int i = 0; i < 4; i++)
			b[i] = {hi[2*i+:2], lo[8*i+:8]};
		wr(9'h090, 16'h0001);
		repeat (2) @(negedge core_clk);
		chk(43'(dout.data), 43'(b));
		chk(43'({dout.valid, dout.frame_valid, dout.line_valid}), 43'(3'b100));
		chk(43'(last), 43'(b));
		wr(9'h090, 16'h0003);
		for (int w = 0; w < 4 && dout.data[0] === b[0]; w++)
			@(negedge core_clk);
		for (int k = 1; k < 4; k++) begin
			for (int i = 0; i < 4; i++)
				chk(43'(dout.data[i]), 43'(10'(b[i] + 10'(k))));
			@(negedge core_clk);
		end
		wr(9'h090, 16'h0004);
		for (int i = 0; i < 4; i++)
			e[i] = 10'(i + 1);
		for (int w = 0; w < 4 && dout.data[0] !== 10'h001; w++)
			@(negedge core_clk);
		for (int k = 0; k < 4; k++) begin
			for (int i = 0; i < 4; i++) begin
				chk(43'(dout.data[i]), 43'(e[i]));
				e[i] = {e[i][8:0], e[i][9] ^ e[i][6]};
			end
			@(negedge core_clk);
		end
		wr(9'h090, 16'h0009);
		repeat (2) @(negedge core_clk);
		for (int k = 0; k < 4; k++) begin
			drive();
			@(negedge core_clk);
			chk(43'(dout.data), 43'(prev.valid ? b : prev.data));
			chk(43'(dout[2:0]), 43'(prev[2:0]));
		end
		// Pseudo-random and incrementing insertion together: the sequence must win
		wr(9'h090, 16'h0007);
		for (int w = 0; w < 4 && dout.data[0] !== 10'h001; w++)
			@(negedge core_clk);
		for (int i = 0; i < 4; i++)
			chk(43'(dout.data[i]), 43'(10'(i + 1)));
		repeat (3) @(negedge core_clk);
		conclude();
	end
endmodule : datapath_test_pattern_gen_tb
bind dtp_pattern_gen dtp_checker u_chk (.core_clk(core_clk), .rst(rst), .reg_req(reg_req), .reg_rsp(reg_rsp),
	.pix_in(pix_in), .cal_done(cal_done), .cal_short(cal_short), .data_out(data_out));
